// *** common/pced_pkg.sv ***
/*
  Package for the pin change edge interrupt block: register offsets,
  field positions, reset values, widths and bus carrier structs.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package pced_pkg;

  // Port widths and implemented pin masks
  localparam int unsigned PORT_W        = 8;
  localparam int unsigned NUM_PORTS     = 2;
  localparam int unsigned ADDR_W        = 12;
  localparam logic [7:0]  PORT_A_MASK   = 8'h3b;
  localparam logic [7:0]  PORT_B_MASK   = 8'hf0;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_A_RISE    = 12'h000;
  localparam logic [11:0] OFF_A_FALL    = 12'h004;
  localparam logic [11:0] OFF_A_FLAGS   = 12'h008;
  localparam logic [11:0] OFF_B_RISE    = 12'h00c;
  localparam logic [11:0] OFF_B_FALL    = 12'h010;
  localparam logic [11:0] OFF_B_FLAGS   = 12'h014;
  localparam logic [11:0] OFF_CTRL      = 12'h018;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h01c;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h020;

  // Control register fields
  localparam int unsigned CTRL_MEN_BIT  = 0;
  localparam int unsigned CTRL_SUM_BIT  = 1;
  localparam int unsigned CTRL_A_BUF_BIT = 2;
  localparam int unsigned CTRL_B_BUF_BIT = 3;

  // Interrupt status fields
  localparam int unsigned IST_EDGE_BIT  = 0;
  localparam int unsigned IST_WAKE_BIT  = 1;
  localparam int unsigned IST_W         = 2;

  // Reset values
  localparam logic [7:0]  RST_ENABLE    = 8'h00;
  localparam logic [7:0]  RST_FLAGS     = 8'h00;
  localparam logic [1:0]  RST_IST       = 2'h0;
  localparam logic [1:0]  RST_IMASK     = 2'h0;
  localparam logic        RST_MEN       = 1'b0;
  localparam logic        RST_BUF_EN    = 1'b1;

  // APB request and answer carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } pced_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pced_apb_rsp_t;

endpackage : pced_pkg

// *** hdl/pced_sync.sv ***
/*
  Two-flop synchroniser for one port of pin inputs.
  Assumes pins are asynchronous to core_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module pced_sync
  import pced_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Pins
  input  wire logic [PORT_W-1:0] pin_i,
  output logic      [PORT_W-1:0] sync_o
);

  logic [PORT_W-1:0] meta_q;
  logic [PORT_W-1:0] sync_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : pced_sync
`default_nettype wire

// *** hdl/pced_port.sv ***
/*
  Edge detection and flag register for one port.
  Assumes synchronised pin levels and a write strobe from the bus slave.
*/
`timescale 1ns/1ns
`default_nettype none
module pced_port
  import pced_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Pin side
  input  wire logic [PORT_W-1:0] sync_i,
  input  wire logic              buf_en_i,
  input  wire logic [PORT_W-1:0] pin_mask_i,
  // Config
  input  wire logic [PORT_W-1:0] rise_en_i,
  input  wire logic [PORT_W-1:0] fall_en_i,
  // Flag write
  input  wire logic              flag_we_i,
  input  wire logic [PORT_W-1:0] flag_wdata_i,
  // Status
  output logic      [PORT_W-1:0] flags_o,
  output logic      [PORT_W-1:0] hit_o
);

  logic [PORT_W-1:0] prev_q;
  logic [PORT_W-1:0] flags_q;
  logic [PORT_W-1:0] flags_d;
  logic [PORT_W-1:0] level;
  logic [PORT_W-1:0] rise;
  logic [PORT_W-1:0] fall;
  logic [PORT_W-1:0] hit;

  // Input buffer gating for bus-shared pins
  assign level   = buf_en_i ? sync_i : prev_q;
  assign rise    = level & ~prev_q & rise_en_i;
  assign fall    = ~level & prev_q & fall_en_i;
  assign hit     = (rise | fall) & pin_mask_i;
  assign flags_d = (flag_we_i ? (flag_wdata_i & flags_q) : flags_q) | hit;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q  <= '0;
      flags_q <= RST_FLAGS;
    end else begin
      prev_q  <= level;
      flags_q <= flags_d & pin_mask_i;
    end
  end

  assign flags_o = flags_q;
  assign hit_o   = hit;

endmodule : pced_port
`default_nettype wire

// *** hdl/pced_top.sv ***
/*
  Pin change edge interrupt block with APB register slave.
  Assumes pins asynchronous to core_clk_i and a single APB master.
*/
// How it works
// - Any implemented pin or pin set may interrupt
// - Master enable gates interrupt, not detection
// - Rise enable bit arms rising detector
// - Fall enable bit arms falling detector
// - Both bits set detect both edges
// - Enabled edge sets pin flag
// - Summary flag is OR of flags
// - Software clears flag by writing zero
// - Edge during write keeps flag set
// - Wake from sleep when master enabled
// - Sleep edge sets flag on same edge as wake
// - Edge and master enable bits reset to zero, buffer enables to one
// - Shared pins need buffers enabled
`timescale 1ns/1ns
`default_nettype none
module pced_top
  import pced_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Pins
  input  wire logic [PORT_W-1:0] port_a_pin_i,
  input  wire logic [PORT_W-1:0] port_b_pin_i,
  // Core side
  input  wire logic              sleep_i,
  output logic                   pin_change_irq_o,
  output logic                   wake_o,
  output logic                   irq_o
);

  pced_apb_req_t req;
  pced_apb_rsp_t rsp;

  logic [PORT_W-1:0] a_rise_q;
  logic [PORT_W-1:0] a_fall_q;
  logic [PORT_W-1:0] b_rise_q;
  logic [PORT_W-1:0] b_fall_q;
  logic              men_q;
  logic              a_buf_q;
  logic              b_buf_q;
  logic [IST_W-1:0]  ist_q;
  logic [IST_W-1:0]  ist_d;
  logic [IST_W-1:0]  imask_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              wake_q;
  logic              irq_q;

  logic [PORT_W-1:0] a_sync;
  logic [PORT_W-1:0] b_sync;
  logic [PORT_W-1:0] a_flags;
  logic [PORT_W-1:0] b_flags;
  logic [PORT_W-1:0] a_hit;
  logic [PORT_W-1:0] b_hit;

  assign req.psel    = psel_i;
  assign req.penable = penable_i;
  assign req.pwrite  = pwrite_i;
  assign req.paddr   = paddr_i;
  assign req.pwdata  = pwdata_i;

  // Access decode
  wire              acc       = req.psel & req.penable;
  wire              wr        = acc & req.pwrite;
  wire              rd        = acc & ~req.pwrite;
  wire              sel_ar    = req.paddr == OFF_A_RISE;
  wire              sel_af    = req.paddr == OFF_A_FALL;
  wire              sel_afl   = req.paddr == OFF_A_FLAGS;
  wire              sel_br    = req.paddr == OFF_B_RISE;
  wire              sel_bf    = req.paddr == OFF_B_FALL;
  wire              sel_bfl   = req.paddr == OFF_B_FLAGS;
  wire              sel_ctl   = req.paddr == OFF_CTRL;
  wire              sel_ist   = req.paddr == OFF_IRQ_STAT;
  wire              sel_imk   = req.paddr == OFF_IRQ_MASK;
  wire              mapped    = sel_ar | sel_af | sel_afl | sel_br | sel_bf | sel_bfl
                                | sel_ctl | sel_ist | sel_imk;
  wire [PORT_W-1:0] wbyte     = req.pwdata[PORT_W-1:0];

  // Change summary and event derivation
  wire              summary   = |{a_flags, b_flags};
  wire              any_hit   = |{a_hit, b_hit};
  wire              wake_ev   = men_q & sleep_i & any_hit;

  wire [31:0] ctrl_word = {28'h0000000, b_buf_q, a_buf_q, summary, men_q};

  // Sticky interrupt status, set beats write-one-clear
  wire [IST_W-1:0] ist_set = {wake_ev, men_q & any_hit};
  wire [IST_W-1:0] ist_clr = (wr & sel_ist) ? req.pwdata[IST_W-1:0] : '0;
  assign ist_d = (ist_q & ~ist_clr) | ist_set;

  // Read mux
  always_comb begin
    rdata_d = 32'h00000000;
    unique case (1'b1)
      sel_ar:  rdata_d[PORT_W-1:0] = a_rise_q;
      sel_af:  rdata_d[PORT_W-1:0] = a_fall_q;
      sel_afl: rdata_d[PORT_W-1:0] = a_flags;
      sel_br:  rdata_d[PORT_W-1:0] = b_rise_q;
      sel_bf:  rdata_d[PORT_W-1:0] = b_fall_q;
      sel_bfl: rdata_d[PORT_W-1:0] = b_flags;
      sel_ctl: rdata_d = ctrl_word;
      sel_ist: rdata_d[IST_W-1:0] = ist_q;
      sel_imk: rdata_d[IST_W-1:0] = imask_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Config registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_rise_q <= RST_ENABLE;
      a_fall_q <= RST_ENABLE;
      b_rise_q <= RST_ENABLE;
      b_fall_q <= RST_ENABLE;
    end else begin
      if (wr && sel_ar) a_rise_q <= wbyte & PORT_A_MASK;
      if (wr && sel_af) a_fall_q <= wbyte & PORT_A_MASK;
      if (wr && sel_br) b_rise_q <= wbyte & PORT_B_MASK;
      if (wr && sel_bf) b_fall_q <= wbyte & PORT_B_MASK;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      men_q   <= RST_MEN;
      a_buf_q <= RST_BUF_EN;
      b_buf_q <= RST_BUF_EN;
      imask_q <= RST_IMASK;
    end else begin
      if (wr && sel_ctl) begin
        men_q   <= req.pwdata[CTRL_MEN_BIT];
        a_buf_q <= req.pwdata[CTRL_A_BUF_BIT];
        b_buf_q <= req.pwdata[CTRL_B_BUF_BIT];
      end
      if (wr && sel_imk) imask_q <= req.pwdata[IST_W-1:0];
    end
  end

  // Status, read data and outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ist_q   <= RST_IST;
      rdata_q <= 32'h00000000;
      wake_q  <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      ist_q   <= ist_d;
      rdata_q <= rd ? rdata_d : rdata_q;
      wake_q  <= wake_ev;
      irq_q   <= men_q & summary;
    end
  end

  assign rsp.pready  = 1'b1;
  assign rsp.pslverr = acc & ~mapped;
  assign rsp.prdata  = rdata_q;

  // Read data registered one edge late would break zero-wait reads, so mux directly
  assign prdata_o  = rd ? rdata_d : rsp.prdata;
  assign pready_o  = rsp.pready;
  assign pslverr_o = rsp.pslverr;

  assign pin_change_irq_o = irq_q;
  assign wake_o           = wake_q;
  assign irq_o            = |(ist_q & imask_q);

  // Port A uses buffer gate on all pins; a_sync_g passes a_sync through unchanged
  wire [PORT_W-1:0] a_sync_g = {a_sync[PORT_W-1:2], a_sync[1:0]};

  pced_sync u_sync_a (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (port_a_pin_i),
    .sync_o     (a_sync)
  );

  pced_sync u_sync_b (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (port_b_pin_i),
    .sync_o     (b_sync)
  );

  pced_port u_port_a (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .sync_i       (a_sync_g),
    .buf_en_i     (a_buf_q),
    .pin_mask_i   (PORT_A_MASK),
    .rise_en_i    (a_rise_q),
    .fall_en_i    (a_fall_q),
    .flag_we_i    (wr & sel_afl),
    .flag_wdata_i (wbyte),
    .flags_o      (a_flags),
    .hit_o        (a_hit)
  );

  pced_port u_port_b (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .sync_i       (b_sync),
    .buf_en_i     (b_buf_q),
    .pin_mask_i   (PORT_B_MASK),
    .rise_en_i    (b_rise_q),
    .fall_en_i    (b_fall_q),
    .flag_we_i    (wr & sel_bfl),
    .flag_wdata_i (wbyte),
    .flags_o      (b_flags),
    .hit_o        (b_hit)
  );

endmodule : pced_top
`default_nettype wire

// *** verif/pced_assertions.sv ***
/* Port checker for pced_top.
   Assumes a bind into pced_top; a pin change reaches the detector
   after two synchroniser flops and one compare edge. */
`timescale 1ns/1ns
`default_nettype none
module pced_assertions
  import pced_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // Bus
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       prdata_o,
  input  wire logic              pready_o,
  input  wire logic              pslverr_o,
  // Pins and core
  input  wire logic [PORT_W-1:0] port_a_pin_i,
  input  wire logic [PORT_W-1:0] port_b_pin_i,
  input  wire logic              sleep_i,
  input  wire logic              pin_change_irq_o,
  input  wire logic              wake_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire acc = psel_i & penable_i;
  wire wr  = acc & pwrite_i;

  a_ready_high: assert property (pready_o) else $error("ready low");
  a_err_access: assert property (pslverr_o |-> acc) else $error("error outside access");
  a_err_rdzero: assert property (acc && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i)) else $error("wake when awake");
  a_wake_pulse: assert property (wake_o |=> !wake_o
    || $past(port_a_pin_i, 3) != $past(port_a_pin_i, 4)
    || $past(port_b_pin_i, 3) != $past(port_b_pin_i, 4)) else $error("wake too long");
  a_wake_cause: assert property (wake_o |-> $past(port_a_pin_i, 3) != $past(port_a_pin_i, 4)
    || $past(port_b_pin_i, 3) != $past(port_b_pin_i, 4)) else $error("wake without edge");
  a_pirq_rise: assert property ($rose(pin_change_irq_o) |-> $past(wr, 2)
    || $past(port_a_pin_i, 4) != $past(port_a_pin_i, 5)
    || $past(port_b_pin_i, 4) != $past(port_b_pin_i, 5)) else $error("irq without cause");
  a_pirq_fall: assert property ($fell(pin_change_irq_o) |-> $past(wr, 2))
    else $error("irq dropped without write");
endmodule : pced_assertions

bind pced_top pced_assertions u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .port_a_pin_i(port_a_pin_i), .port_b_pin_i(port_b_pin_i), .sleep_i(sleep_i),
  .pin_change_irq_o(pin_change_irq_o), .wake_o(wake_o)
);
`default_nettype wire

// *** verif/pced_pin_model.sv ***
/* Pin levels of both ports as driven from outside.
   Assumes levels change just after a core clock edge. */
`timescale 1ns/1ns
`default_nettype none
module pced_pin_model
  import pced_pkg::*;
(
  // Clock
  input  wire logic              core_clk_i,
  // Pins
  output logic      [PORT_W-1:0] port_a_o,
  output logic      [PORT_W-1:0] port_b_o
);
  initial begin
    port_a_o = '0;
    port_b_o = '0;
  end
  task automatic drive(input logic [PORT_W-1:0] a, input logic [PORT_W-1:0] b);
    @(posedge core_clk_i);
    port_a_o <= a;
    port_b_o <= b;
  endtask : drive
endmodule : pced_pin_model
`default_nettype wire

// *** verif/tb.sv ***
/* Self-checking bench: APB register access and pin edge scenarios.
   Assumes the pin model and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb
  import pced_pkg::*;
;
  logic              core_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              sleep = 1'b0;
  pced_apb_req_t     req = '0;
  pced_apb_rsp_t     rsp;
  logic [PORT_W-1:0] pa;
  logic [PORT_W-1:0] pb;
  logic              pirq;
  logic              wake;
  logic              irq;
  logic [31:0]       rd;
  logic              err;
  logic              seen;
  int                n_mismatch = 0;
  int                check_count = 0;

  always #5 core_clk_i = ~core_clk_i;

  pced_pin_model pins (.core_clk_i(core_clk_i), .port_a_o(pa), .port_b_o(pb));
  pced_top dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(req.psel), .penable_i(req.penable),
    .pwrite_i(req.pwrite), .paddr_i(req.paddr), .pwdata_i(req.pwdata),
    .prdata_o(rsp.prdata), .pready_o(rsp.pready), .pslverr_o(rsp.pslverr),
    .port_a_pin_i(pa), .port_b_pin_i(pb), .sleep_i(sleep),
    .pin_change_irq_o(pirq), .wake_o(wake), .irq_o(irq)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge core_clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
      i++;
    end while (rsp.pready !== 1'b1 && i < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc

  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rdc(OFF_A_RISE, 32'h0);
    rdc(OFF_CTRL, 32'hc);
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK(err, 1'b1)
    $display("test reset done");
    wr(OFF_A_RISE, 32'hff);
    rdc(OFF_A_RISE, {24'h0, PORT_A_MASK});
    pins.drive(8'hff, 8'h00);
    repeat (6) @(posedge core_clk_i);
    rdc(OFF_A_FLAGS, {24'h0, PORT_A_MASK});
    rdc(OFF_CTRL, 32'he);
    `CHK(pirq, 1'b0)
    wr(OFF_A_FLAGS, 32'h0);
    pins.drive(8'h00, 8'h00);
    repeat (6) @(posedge core_clk_i);
    rdc(OFF_A_FLAGS, 32'h0);
    $display("test edge kinds done");
    wr(OFF_B_RISE, 32'hff);
    wr(OFF_B_FALL, 32'h10);
    pins.drive(8'h00, 8'hff);
    repeat (6) @(posedge core_clk_i);
    rdc(OFF_B_FLAGS, 32'hf0);
    wr(OFF_B_FLAGS, ~32'hf0);
    rdc(OFF_B_FLAGS, 32'h0);
    pins.drive(8'h00, 8'h00);
    repeat (6) @(posedge core_clk_i);
    rdc(OFF_B_FLAGS, 32'h10);
    wr(OFF_B_FLAGS, 32'h0);
    $display("test both edges done");
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CTRL, 32'hd);
    pins.drive(8'h00, 8'h10);
    repeat (6) @(posedge core_clk_i);
    `CHK(pirq, 1'b1)
    rdc(OFF_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_STAT, 32'h1);
    wr(OFF_B_FLAGS, 32'h0);
    repeat (2) @(posedge core_clk_i);
    `CHK(irq, 1'b0)
    `CHK(pirq, 1'b0)
    pins.drive(8'h01, 8'h00);
    wr(OFF_A_FLAGS, 32'h0);
    rdc(OFF_A_FLAGS, 32'h1);
    $display("test interrupt done");
    wr(OFF_A_FLAGS, 32'h0);
    wr(OFF_IRQ_STAT, 32'h3);
    sleep <= 1'b1;
    pins.drive(8'h03, 8'h00);
    seen = 1'b0;
    repeat (10) begin
      @(posedge core_clk_i);
      if (wake === 1'b1) seen = 1'b1;
    end
    `CHK(seen, 1'b1)
    rdc(OFF_A_FLAGS, 32'h2);
    rdc(OFF_IRQ_STAT, 32'h3);
    sleep <= 1'b0;
    wr(OFF_CTRL, 32'h9);
    wr(OFF_A_FLAGS, 32'h0);
    pins.drive(8'h3b, 8'h00);
    repeat (6) @(posedge core_clk_i);
    rdc(OFF_A_FLAGS, 32'h0);
    $display("test sleep and buffers done");
    summarize();
  end
endmodule : tb
`default_nettype wire
